// ===== hw/sram_ctl_pkg.sv
// Purpose: Shared constants and types for the static memory controller
// Assumes: 20 MHz core clock, 50 ns period
// Notes: Timing figures kept in ns; cycle counts derived from them
package sram_ctl_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int WORDS = 32768;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // Slower speed grade figures, so one setting serves both grades
  localparam int WRITE_PULSE_MIN_NS = 10;
  localparam int BYTE_ENABLE_TO_WRITE_END_MIN_NS = 9;
  localparam int DATA_SETUP_MIN_NS = 8;
  localparam int READ_ACCESS_MAX_NS = 15;
  localparam int BUS_TURN_MIN_NS = 7;
  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WRITE_CYC = ns_to_cyc(
    (WRITE_PULSE_MIN_NS > BYTE_ENABLE_TO_WRITE_END_MIN_NS) ?
    WRITE_PULSE_MIN_NS : BYTE_ENABLE_TO_WRITE_END_MIN_NS);
  localparam int READ_CYC = ns_to_cyc(READ_ACCESS_MAX_NS);
  localparam int TURN_CYC = ns_to_cyc(BUS_TURN_MIN_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WSETUP = 5'h02,
    ST_WPULSE = 5'h04,
    ST_RTURN = 5'h08,
    ST_RWAIT = 5'h10
  } ctl_state_t;
endpackage

// ===== hw/sram_host_ctl.sv
// Purpose: Host controller driving an asynchronous 32K x 16 static memory
// Assumes: Memory data pins sampled synchronously to core_clk_in
// Notes: One access at a time; write window is the strobe pulse alone
// ---------------------------------------------------------------
// What this block does
// - Controller drops select, strobe and wanted lane enables low to write.
// - Write data set-up and hold timed to the first rising signal.
// - Write strobe held high through every read cycle.
// - Address valid no later than select falling in a read.
// - Lane enable low at least 9 ns before write ends.
// ---------------------------------------------------------------
module sram_host_ctl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // User request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic [sram_ctl_pkg::LANES-1:0] req_lanes_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [sram_ctl_pkg::DATA_W-1:0] rsp_rdata_out,
  // Memory pins
  output logic [sram_ctl_pkg::ADDR_W-1:0] mem_addr_out,
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out,
  output logic low_byte_enable_n_out,
  output logic high_byte_enable_n_out,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] mem_data_in,
  output logic [sram_ctl_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_out
);
  sram_ctl_pkg::ctl_state_t state_r;
  logic [sram_ctl_pkg::LANES-1:0] lanes_r;
  sram_timer_if tif ();

  sram_phase_timer u_timer (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .tif(tif)
  );

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  // Empty lane mask is promoted to both lanes so a write always lands
  function automatic logic [sram_ctl_pkg::LANES-1:0] lane_fix(
    input logic [sram_ctl_pkg::LANES-1:0] l);
    return (l == '0) ? '1 : l;
  endfunction

  // Timer loads on every phase entry
  always_comb begin
    tif.load = 1'b0;
    tif.count = sram_ctl_pkg::CNT_ONE;
    case (state_r)
      sram_ctl_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          tif.load = 1'b1;
          tif.count = sram_ctl_pkg::CNT_W'(
            req_write_in ? 1 : sram_ctl_pkg::TURN_CYC);
        end
      end
      sram_ctl_pkg::ST_WSETUP: begin
        tif.load = tif.done;
        tif.count = sram_ctl_pkg::CNT_W'(sram_ctl_pkg::WRITE_CYC);
      end
      sram_ctl_pkg::ST_RTURN: begin
        tif.load = tif.done;
        tif.count = sram_ctl_pkg::CNT_W'(sram_ctl_pkg::READ_CYC + 1);
      end
      default: begin
        tif.load = 1'b0;
      end
    endcase
  end

  // Phase state; every phase waits out its timer
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= sram_ctl_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sram_ctl_pkg::ST_IDLE: begin
          if (req_valid_in) begin
            state_r <= req_write_in ? sram_ctl_pkg::ST_WSETUP
                                    : sram_ctl_pkg::ST_RTURN;
          end
        end
        sram_ctl_pkg::ST_WSETUP: begin
          if (tif.done) state_r <= sram_ctl_pkg::ST_WPULSE;
        end
        sram_ctl_pkg::ST_WPULSE: begin
          if (tif.done) state_r <= sram_ctl_pkg::ST_IDLE;
        end
        sram_ctl_pkg::ST_RTURN: begin
          if (tif.done) state_r <= sram_ctl_pkg::ST_RWAIT;
        end
        sram_ctl_pkg::ST_RWAIT: begin
          if (tif.done) state_r <= sram_ctl_pkg::ST_IDLE;
        end
        default: state_r <= sram_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address, data and lanes captured once per access
  // ---------------------------------------------------------------
  // Address set before select falls and held to the end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_addr_out <= '0;
      mem_data_out <= '0;
      lanes_r <= '0;
    end else if (state_r == sram_ctl_pkg::ST_IDLE && req_valid_in) begin
      mem_addr_out <= req_addr_in;
      mem_data_out <= req_wdata_in;
      lanes_r <= lane_fix(req_lanes_in);
    end
  end

  // ---------------------------------------------------------------
  // Memory control pins
  // ---------------------------------------------------------------
  // Select and lanes span the access; strobe sits inside them, so the
  // strobe rising alone ends every write with data still held
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chip_select_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      low_byte_enable_n_out <= 1'b1;
      high_byte_enable_n_out <= 1'b1;
      mem_data_oe_out <= 1'b0;
    end else begin
      case (state_r)
        sram_ctl_pkg::ST_WSETUP: begin
          chip_select_n_out <= 1'b0;
          low_byte_enable_n_out <= ~lanes_r[0];
          high_byte_enable_n_out <= ~lanes_r[1];
          mem_data_oe_out <= 1'b1;
          write_strobe_n_out <= ~tif.done;
        end
        sram_ctl_pkg::ST_WPULSE: begin
          // Strobe rises first; data stays one more cycle for hold
          write_strobe_n_out <= tif.done;
        end
        sram_ctl_pkg::ST_RTURN: begin
          write_strobe_n_out <= 1'b1;
          mem_data_oe_out <= 1'b0;
          chip_select_n_out <= 1'b0;
          low_byte_enable_n_out <= ~lanes_r[0];
          high_byte_enable_n_out <= ~lanes_r[1];
          output_enable_n_out <= ~tif.done;
        end
        sram_ctl_pkg::ST_RWAIT: begin
          write_strobe_n_out <= 1'b1;
          if (tif.done) begin
            output_enable_n_out <= 1'b1;
          end
        end
        default: begin
          // Idle: deselect so memory floats its pins
          chip_select_n_out <= 1'b1;
          write_strobe_n_out <= 1'b1;
          output_enable_n_out <= 1'b1;
          low_byte_enable_n_out <= 1'b1;
          high_byte_enable_n_out <= 1'b1;
          mem_data_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // User handshake
  // ---------------------------------------------------------------
  // Ready only in idle; registered, so it drops the cycle after a request is taken
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state_r == sram_ctl_pkg::ST_IDLE) ? ~req_valid_in
        : ((state_r == sram_ctl_pkg::ST_WPULSE ||
            state_r == sram_ctl_pkg::ST_RWAIT) && tif.done);
    end
  end

  // Read data sampled at the end of the wait, disabled lanes zeroed
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (state_r == sram_ctl_pkg::ST_RWAIT && tif.done) begin
        rsp_valid_out <= 1'b1;
        rsp_rdata_out <= mem_data_in &
          {{sram_ctl_pkg::LANE_W{lanes_r[1]}},
           {sram_ctl_pkg::LANE_W{lanes_r[0]}}};
      end
    end
  end
endmodule

// ===== hw/sram_phase_timer.sv
// Purpose: Down counter that times each bus phase
// Assumes: Count of at least one cycle
// Notes: Done is a one-cycle pulse from a flip-flop
module sram_phase_timer (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Controller side
  sram_timer_if.tmr tif
);
  logic [sram_ctl_pkg::CNT_W-1:0] left_r;
  logic done_r;

  // Count down, pulse done on the last cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      left_r <= sram_ctl_pkg::CNT_ZERO;
      done_r <= 1'b0;
    end else if (tif.load) begin
      left_r <= tif.count;
      done_r <= 1'b0;
    end else begin
      done_r <= (left_r == sram_ctl_pkg::CNT_ONE);
      if (left_r != sram_ctl_pkg::CNT_ZERO) begin
        left_r <= left_r - sram_ctl_pkg::CNT_ONE;
      end
    end
  end
  assign tif.done = done_r;
endmodule

// ===== hw/sram_timer_if.sv
// Purpose: Link between the controller and its phase timer
// Assumes: One clock domain
// Notes: Load starts a count; done pulses when it expires
interface sram_timer_if;
  logic load;
  logic [sram_ctl_pkg::CNT_W-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ===== sim/sram_async_model.sv
// Purpose: Behavioural 32K x 16 static memory with byte lanes
// Assumes: Write data sampled on the controller clock
// Notes: Lane drive flags let the bench resolve the shared bus
module sram_async_model (
  // Sampling clock
  input wire logic core_clk_in,
  // Memory pins
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_in,
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic lo_n_in,
  input wire logic hi_n_in,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] bus_in,
  output logic [sram_ctl_pkg::DATA_W-1:0] rd_data_out,
  output logic [1:0] lane_drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cells [sram_ctl_pkg::WORDS];
  logic rd_ok;
  // Drive only in a read; select rising with strobe stays floating
  assign rd_ok = !cs_n_in && !oe_n_in && we_n_in;
  assign lane_drive_out = {rd_ok && !hi_n_in, rd_ok && !lo_n_in};
  assign rd_data_out = cells[addr_in];
  // Store only inside the three-way overlap window
  always @(posedge core_clk_in) begin
    if (!cs_n_in && !we_n_in && !lo_n_in) begin
      cells[addr_in][7:0] <= bus_in[7:0];
    end
    if (!cs_n_in && !we_n_in && !hi_n_in) begin
      cells[addr_in][15:8] <= bus_in[15:8];
    end
  end
endmodule

// ===== sim/sram_host_ctl_props.sv
// Purpose: Pin-level checks on the static memory controller
// Assumes: Top module ports only, one clock domain
// Notes: Bound to every instance of the controller
module sram_host_ctl_props (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Watched ports
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_ready_out,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic chip_select_n_out,
  input wire logic write_strobe_n_out,
  input wire logic output_enable_n_out,
  input wire logic low_byte_enable_n_out,
  input wire logic high_byte_enable_n_out,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // -------------------------------------------------------------
  // Steps of an access
  // -------------------------------------------------------------
  wire logic lane_on = !low_byte_enable_n_out || !high_byte_enable_n_out;
  sequence s_take_wr;
    req_valid_in && req_ready_out && req_write_in;
  endsequence
  sequence s_take_rd;
    req_valid_in && req_ready_out && !req_write_in;
  endsequence
  sequence s_write_end;
    !write_strobe_n_out ##1 write_strobe_n_out;
  endsequence
  property p_write_qual;
    !write_strobe_n_out |-> !chip_select_n_out && lane_on;
  endproperty
  a_write_qual: assert property (p_write_qual)
    else $error("strobe low without select or lane");
  property p_write_start;
    s_take_wr |-> ##[1:6] !write_strobe_n_out;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write request gave no strobe");
  // Strobe ends the write, so data must outlive it
  property p_data_hold;
    s_write_end |-> mem_data_oe_out && $stable(mem_data_out)
      && !chip_select_n_out;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held at strobe end");
  property p_lane_span;
    s_write_end |-> $past(lane_on, 2) && $past(lane_on, 1);
  endproperty
  a_lane_span: assert property (p_lane_span)
    else $error("lane enable too short before write end");
  property p_read_we;
    !output_enable_n_out |-> write_strobe_n_out;
  endproperty
  a_read_we: assert property (p_read_we)
    else $error("strobe low while outputs enabled");
  property p_read_hold;
    s_take_rd |=> write_strobe_n_out [*6];
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("strobe fell during a read");
  property p_addr_hold;
    !chip_select_n_out && $past(!chip_select_n_out) |->
      $stable(mem_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved while selected");
  property p_turn;
    !output_enable_n_out |-> !mem_data_oe_out && $past(!mem_data_oe_out);
  endproperty
  a_turn: assert property (p_turn)
    else $error("bus driven while memory outputs enabled");
endmodule
bind sram_host_ctl sram_host_ctl_props u_props (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .req_valid_in(req_valid_in), .req_write_in(req_write_in),
  .req_ready_out(req_ready_out), .mem_addr_out(mem_addr_out),
  .chip_select_n_out(chip_select_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .output_enable_n_out(output_enable_n_out),
  .low_byte_enable_n_out(low_byte_enable_n_out),
  .high_byte_enable_n_out(high_byte_enable_n_out),
  .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));

// ===== sim/sram_host_ctl_tb_top.sv
// Purpose: Self-checking bench for the static memory controller
// Assumes: 20 MHz clock, reset held ten cycles
// Notes: Undriven bus lanes show a toggling pattern, never old data
module sram_host_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr; logic [14:0] a; logic [15:0] d; logic [1:0] l;
    logic [15:0] exp;
  } row_t;
  logic core_clk_in, reset_n_in, req_valid_in, req_write_in;
  logic [14:0] req_addr_in, mem_addr_out;
  logic [15:0] req_wdata_in, rsp_rdata_out, mem_data_out, bus, dev;
  logic [1:0] req_lanes_in, drv;
  logic req_ready_out, rsp_valid_out, cs_n, we_n, oe_n, lo_n, hi_n;
  logic mem_data_oe_out;
  logic noise_r = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  // Ordinary cases: lane masks, boundary addresses, 00 means both
  row_t rows [10] = '{'{1'b1, 15'h0, 16'h1234, 2'h3, 16'h0},
    '{1'b0, 15'h0, 16'h0, 2'h3, 16'h1234},
    '{1'b1, 15'h0, 16'habcd, 2'h1, 16'h0},
    '{1'b0, 15'h0, 16'h0, 2'h3, 16'h12cd},
    '{1'b1, 15'h0, 16'hef56, 2'h2, 16'h0},
    '{1'b0, 15'h0, 16'h0, 2'h1, 16'h00cd},
    '{1'b0, 15'h0, 16'h0, 2'h2, 16'hef00},
    '{1'b1, 15'h7fff, 16'h5aa5, 2'h0, 16'h0},
    '{1'b0, 15'h7fff, 16'h0, 2'h0, 16'h5aa5},
    '{1'b0, 15'h0, 16'h0, 2'h3, 16'hefcd}};
  // Pin walk of one write: {select, strobe, oe, low, high, drive}
  logic [5:0] walk [6] = '{6'h3e, 6'h19, 6'h09, 6'h09, 6'h19, 6'h3e};
  sram_host_ctl u_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_lanes_in(req_lanes_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .mem_addr_out(mem_addr_out), .chip_select_n_out(cs_n),
    .write_strobe_n_out(we_n), .output_enable_n_out(oe_n),
    .low_byte_enable_n_out(lo_n), .high_byte_enable_n_out(hi_n),
    .mem_data_in(bus), .mem_data_out(mem_data_out),
    .mem_data_oe_out(mem_data_oe_out));
  sram_async_model u_mem (.core_clk_in(core_clk_in), .addr_in(mem_addr_out),
    .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .lo_n_in(lo_n),
    .hi_n_in(hi_n), .bus_in(bus), .rd_data_out(dev), .lane_drive_out(drv));
  // Bus level per lane from both parties' enables
  assign bus[7:0] = mem_data_oe_out ? mem_data_out[7:0] :
    drv[0] ? dev[7:0] : {8{noise_r}} ^ 8'h5a;
  assign bus[15:8] = mem_data_oe_out ? mem_data_out[15:8] :
    drv[1] ? dev[15:8] : {8{noise_r}} ^ 8'ha5;
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) noise_r <= ~noise_r;
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, held until the take edge; reads wait for the answer
  task automatic access(input row_t r);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (req_ready_out !== 1'b1 && n < 50) begin
      @(negedge core_clk_in);
      n++;
    end
    // A ready that never comes is a failure, not a skip
    if (n >= 50) errors++;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    {req_write_in, req_addr_in, req_wdata_in, req_lanes_in} <=
      {r.wr, r.a, r.d, r.l};
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    if (!r.wr) begin
      n = 0;
      @(negedge core_clk_in);
      while (rsp_valid_out !== 1'b1 && n < 20) begin
        @(negedge core_clk_in);
        n++;
      end
      if (n >= 20) errors++;
      chk_data(rsp_rdata_out, r.exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    core_clk_in = 1'b0;
    reset_n_in = 1'b0;
    req_valid_in = 1'b0;
    {req_write_in, req_addr_in, req_wdata_in, req_lanes_in} = '0;
    repeat (10) @(posedge core_clk_in);
    chk_pins({cs_n, we_n, oe_n, lo_n, hi_n, mem_data_oe_out}, 6'h3e);
    reset_n_in <= 1'b1;
    foreach (rows[i]) access(rows[i]);
    // Write walk: strobe nested inside select and lanes, one cycle each
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    {req_write_in, req_addr_in, req_wdata_in, req_lanes_in} <=
      {1'b1, 15'h1, 16'h0f0f, 2'h3};
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    foreach (walk[k]) begin
      @(negedge core_clk_in);
      chk_pins({cs_n, we_n, oe_n, lo_n, hi_n, mem_data_oe_out}, walk[k]);
    end
    chk_data({1'b0, mem_addr_out}, 16'h0001);
    chk_data(mem_data_out, 16'h0f0f);
    access('{1'b0, 15'h1, 16'h0, 2'h3, 16'h0f0f});
    // Reset in mid-read must drop every pin back to idle
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    {req_write_in, req_lanes_in} <= 3'h3;
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    @(negedge core_clk_in);
    chk_pins({cs_n, we_n, oe_n, lo_n, hi_n, mem_data_oe_out}, 6'h3e);
    @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    access(rows[8]);
    print_verdict();
  end
endmodule
